//--- rtl/ebcs_port1.sv
// second general port: quasi-bidirectional drivers and alternate functions
`timescale 1ns/1ps
module ebcs_port1 (
    // clock and reset
    input  wire logic                   mclk_i,
    input  wire logic                   rst_i,
    // port latch write
    input  wire logic                   wr_i,
    input  wire logic [7:0]             wdata_i,
    input  wire logic                   serial1_transmit_i,
    // pins
    input  wire logic [7:0]             pin_i,
    output logic      [7:0]             pin_o,
    output logic      [7:0]             pin_oe_o,
    output logic      [7:0]             pin_pu_o,
    // filtered pin levels and alternate functions
    output logic      [7:0]             val_o,
    output ebcs_pkg::ebcs_alt_type      alt_o
);
    localparam ebcs_pkg::ebcs_port_state_type RST = '{
        latch: ebcs_pkg::PORT1_RST, boost: 8'h00, pin: ebcs_pkg::PORT1_RST,
        oe: 8'h00, pu: ebcs_pkg::PORT1_RST, prev: ebcs_pkg::PORT1_RST,
        alt: '{1'b1, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0}};

    ebcs_pkg::ebcs_port_state_type q, d;
    logic [7:0]                    filt;
    logic [7:0]                    eff;

    ebcs_sync3 #(
        .W       (8),
        .RST_VAL (ebcs_pkg::PORT1_RST)
    ) u_pin_sync (
        .mclk_i (mclk_i),
        .rst_i  (rst_i),
        .d_i    (pin_i),
        .q_o    (filt)
    );

    always_comb begin
        d       = q;
        d.boost = 8'h00;
        if (wr_i) begin
            d.boost = wdata_i & ~q.latch;
            d.latch = wdata_i;
        end
        // transmit line gates the latch of bit 3
        eff    = d.latch;
        eff[3] = d.latch[3] & serial1_transmit_i;
        d.pin  = eff | d.boost;
        d.oe   = ~eff | d.boost;
        d.pu   = eff & ~d.boost;
        d.prev = filt;
        d.alt.timer2_ext_io          = filt[0];
        d.alt.timer2_capture_trigger = filt[1];
        d.alt.serial1_receive        = filt[2];
        d.alt.ext_irq_two   = filt[4] & ~q.prev[4];
        d.alt.ext_irq_three = ~filt[5] & q.prev[5];
        d.alt.ext_irq_four  = filt[6] & ~q.prev[6];
        d.alt.ext_irq_five  = ~filt[7] & q.prev[7];
    end

    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            q <= RST;
        end else begin
            q <= d;
        end
    end

    assign pin_o    = q.pin;
    assign pin_oe_o = q.oe;
    assign pin_pu_o = q.pu;
    assign val_o    = filt;
    assign alt_o    = q.alt;

    default clocking @(posedge mclk_i); endclocking
    default disable iff (rst_i);

    a_port_reset_idle: assert property (disable iff (1'b0)
        rst_i |-> pin_pu_o == 8'hFF && pin_oe_o == 8'h00)
        else $error("port not released to weak pull-up in reset");
    a_zero_pulls_down: assert property (
        wr_i |=> ((pin_oe_o & ~pin_o) & 8'hF7) == (~$past(wdata_i) & 8'hF7))
        else $error("written zero does not pull the pin down");
    a_boost_pulse_once: assert property (
        wr_i |=> (pin_oe_o & pin_o) == ($past(wdata_i) & ~$past(q.latch))
            ##1 ($past(wr_i) || (pin_oe_o & pin_o) == 8'h00))
        else $error("strong high driver not a single brief pulse");
    a_alt_pin_map: assert property (
        {alt_o.timer2_ext_io, alt_o.timer2_capture_trigger,
         alt_o.serial1_receive} == {$past(filt[0]), $past(filt[1]),
         $past(filt[2])})
        else $error("alternate inputs mapped to wrong bits");
    a_irq_edge_sense: assert property (
        {alt_o.ext_irq_two, alt_o.ext_irq_three, alt_o.ext_irq_four,
         alt_o.ext_irq_five} ==
        {$past(filt[4]) && !$past(filt[4], 2),
         !$past(filt[5]) && $past(filt[5], 2),
         $past(filt[6]) && !$past(filt[6], 2),
         !$past(filt[7]) && $past(filt[7], 2)})
        else $error("interrupt edge sense wrong");
endmodule

//--- rtl/ebcs_sync3.sv
// three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
module ebcs_sync3 #(
    parameter int         W       = 8,
    parameter logic [W-1:0] RST_VAL = '0
) (
    // clock and reset
    input  wire logic         mclk_i,
    input  wire logic         rst_i,
    // asynchronous level in, filtered level out
    input  wire logic [W-1:0] d_i,
    output logic      [W-1:0] q_o
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
        logic [W-1:0] s3;
        logic [W-1:0] filt;
    } ebcs_sync_state_type;

    ebcs_sync_state_type q, d;
    logic [W-1:0]        differ;

    if (W < 1) begin : g_chk
        $error("sync width must be at least one");
    end

    always_comb begin
        d      = q;
        d.s1   = d_i;
        d.s2   = q.s1;
        d.s3   = q.s2;
        // a bit changes only once the second and third stages agree
        differ = q.s2 ^ q.s3;
        d.filt = (q.s2 & ~differ) | (q.filt & differ);
    end

    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            q <= '{RST_VAL, RST_VAL, RST_VAL, RST_VAL};
        end else begin
            q <= d;
        end
    end

    // agreement shows at once, so the filter adds no stage of its own
    assign q_o = d.filt;
endmodule

//--- rtl/ebcs_top.sv
// external bus timing, data move stretch and second general port
// Function
// - address-latch strobe high one and a half crystal clocks every four
// - address-latch strobe held high throughout reset
// - low address driven and latched on strobe before data on shared port
// - second port resets to ones held only by weak pull-up
// - written zero turns on strong pull-down until one written or reset
// - zero-to-one write gives brief strong high drive then weak pull-up
// - bits 0-3 map to timer-2 input, trigger, serial-1 receive, transmit
// - bits 4,6 rising-edge interrupts two,four; bits 5,7 falling three,five
// - machine cycle spans exactly four crystal clocks
// - one address-latch pulse per machine cycle; instructions one to five
// - timer tick every twelve crystal clocks, or four when selected
// - data move lasts stretch plus two machine cycles
// - stretch 0-7 writable in clock control register at 8Eh
// - stretch resets to 1, three-cycle data moves
// - stretch leaves program fetch timing untouched
// - stretch occupies clock control bits 2 down to 0
// - strobe 2 clocks at stretch 0, else four clocks per step
`timescale 1ns/1ps
module ebcs_top (
    // clock and reset
    input  wire logic                  mclk_i,
    input  wire logic                  rst_i,
    // special function space access
    input  wire logic [7:0]            sfr_addr_i,
    input  wire logic                  sfr_wr_i,
    input  wire logic [7:0]            sfr_wdata_i,
    output logic      [7:0]            sfr_rdata_o,
    // core bus requests
    input  wire logic                  req_i,
    input  wire ebcs_pkg::ebcs_req_type req_data_i,
    output logic                       idle_o,
    output logic                       done_o,
    output logic      [7:0]            rdata_o,
    // external memory bus
    output logic                       ale_o,
    output logic      [7:0]            mux_addr_data_o,
    output logic                       mux_addr_data_oe_o,
    input  wire logic [7:0]            mux_addr_data_i,
    output logic      [7:0]            addr_hi_o,
    output logic                       rd_n_o,
    output logic                       wr_n_o,
    output logic                       psen_n_o,
    // timer rate
    output logic                       timer_tick_o,
    // second general port
    input  wire logic [7:0]            second_port_pins_i,
    output logic      [7:0]            second_port_pins_o,
    output logic      [7:0]            second_port_pins_oe_o,
    output logic      [7:0]            second_port_pins_pu_o,
    input  wire logic                  serial1_transmit_i,
    output ebcs_pkg::ebcs_alt_type     alt_o
);
    localparam ebcs_pkg::ebcs_top_state_type RST = '{
        st: ebcs_pkg::SEQ_IDLE, ale: 1'b1,
        clk_ctrl_reg: ebcs_pkg::CLK_CTRL_RST, rd_n: 1'b1, wr_n: 1'b1,
        psen_n: 1'b1, idle: 1'b1, default: '0};
    localparam int W = ebcs_pkg::SEQ_W;

    ebcs_pkg::ebcs_top_state_type q, d;
    logic [7:0]   ad_sync;
    logic [7:0]   port_val;
    logic         port_wr;
    logic [3:0]   tdiv;
    logic [2:0]   s_now;
    logic         start;

    if (ebcs_pkg::MC_MCLK != 8) begin : g_chk
        $error("machine cycle must span eight mclk periods");
    end

    // strobe width in mclk for a stretch value
    function automatic logic [W-1:0] strobe_mclk(input logic [2:0] s);
        if (s == 3'd0) begin
            return W'(ebcs_pkg::STRB0_XTAL * ebcs_pkg::MCLK_PER_XTAL);
        end
        return W'(ebcs_pkg::STRB_STEP_XTAL * ebcs_pkg::MCLK_PER_XTAL)
            * {{(W-3){1'b0}}, s};
    endfunction

    assign port_wr = sfr_wr_i && (sfr_addr_i == ebcs_pkg::PORT1_ADDR);
    assign s_now   = q.clk_ctrl_reg[ebcs_pkg::STRETCH_LSB +: ebcs_pkg::STRETCH_W];
    assign start   = (q.st == ebcs_pkg::SEQ_IDLE) && req_i && (q.ph == 3'd7);

    ebcs_sync3 #(
        .W       (8),
        .RST_VAL (8'h00)
    ) u_ad_sync (
        .mclk_i (mclk_i),
        .rst_i  (rst_i),
        .d_i    (mux_addr_data_i),
        .q_o    (ad_sync)
    );

    ebcs_port1 u_port1 (
        .mclk_i             (mclk_i),
        .rst_i              (rst_i),
        .wr_i               (port_wr),
        .wdata_i            (sfr_wdata_i),
        .serial1_transmit_i (serial1_transmit_i),
        .pin_i              (second_port_pins_i),
        .pin_o              (second_port_pins_o),
        .pin_oe_o           (second_port_pins_oe_o),
        .pin_pu_o           (second_port_pins_pu_o),
        .val_o              (port_val),
        .alt_o              (alt_o)
    );

    always_comb begin
        d      = q;
        d.done = 1'b0;
        d.tick = 1'b0;
        // free-running machine cycle of eight mclk, strobe high for three
        d.ph  = q.ph + 3'd1;
        d.ale = (d.ph < 3'(ebcs_pkg::ALE_HIGH_MCLK));
        // timer tick on crystal edges, divider chosen by clock control
        tdiv = q.clk_ctrl_reg[ebcs_pkg::TSEL_BIT] ? 4'(ebcs_pkg::TMR_FAST_XTAL)
                                           : 4'(ebcs_pkg::TMR_SLOW_XTAL);
        if (q.ph[0]) begin
            if (q.tcnt >= tdiv - 4'd1) begin
                d.tcnt = 4'd0;
                d.tick = 1'b1;
            end else begin
                d.tcnt = q.tcnt + 4'd1;
            end
        end
        if (sfr_wr_i && sfr_addr_i == ebcs_pkg::CLK_CTRL_ADDR) begin
            d.clk_ctrl_reg = sfr_wdata_i;
        end
        case (sfr_addr_i)
            ebcs_pkg::CLK_CTRL_ADDR: d.sfr_rdata = q.clk_ctrl_reg;
            ebcs_pkg::PORT1_ADDR:    d.sfr_rdata = port_val;
            default:                 d.sfr_rdata = 8'h00;
        endcase
        case (q.st)
            ebcs_pkg::SEQ_IDLE: begin
                if (start) begin
                    d.st      = ebcs_pkg::SEQ_ADDR;
                    d.cnt     = '0;
                    d.fetch   = req_data_i.fetch;
                    d.we      = req_data_i.we && !req_data_i.fetch;
                    d.ad      = req_data_i.addr[7:0];
                    d.ad_oe   = 1'b1;
                    d.addr_hi = req_data_i.addr[15:8];
                    if (req_data_i.fetch) begin
                        d.len      = W'(ebcs_pkg::FETCH_MC
                                        * ebcs_pkg::MC_MCLK);
                        d.sb_start = W'(ebcs_pkg::ADDR_HOLD_MCLK);
                        d.sb_end   = W'(ebcs_pkg::FETCH_MC
                                        * ebcs_pkg::MC_MCLK);
                    end else begin
                        // stretch caught here only
                        d.len      = ({{(W-3){1'b0}}, s_now}
                                      + W'(ebcs_pkg::BASE_MC))
                                     * W'(ebcs_pkg::MC_MCLK);
                        d.sb_start = W'(ebcs_pkg::MC_MCLK);
                        d.sb_end   = W'(ebcs_pkg::MC_MCLK)
                                     + strobe_mclk(s_now);
                    end
                end
            end
            ebcs_pkg::SEQ_ADDR: begin
                d.cnt = q.cnt + W'(1);
                // address held one mclk past the strobe fall
                if (q.cnt == W'(ebcs_pkg::ADDR_HOLD_MCLK - 1)) begin
                    d.ad    = req_data_i.wdata;
                    d.ad_oe = q.we;
                end
                if (q.cnt == q.sb_start - W'(1)) begin
                    d.st     = ebcs_pkg::SEQ_STRB;
                    d.psen_n = !q.fetch;
                    d.wr_n   = !q.we;
                    d.rd_n   = q.fetch || q.we;
                end
            end
            ebcs_pkg::SEQ_STRB: begin
                d.cnt = q.cnt + W'(1);
                if (q.cnt == q.sb_end - W'(1)) begin
                    d.rd_n   = 1'b1;
                    d.wr_n   = 1'b1;
                    d.psen_n = 1'b1;
                    if (!q.we) begin
                        d.rdata = ad_sync;
                    end
                    d.st = ebcs_pkg::SEQ_TAIL;
                    if (q.cnt == q.len - W'(1)) begin
                        d.st    = ebcs_pkg::SEQ_IDLE;
                        d.done  = 1'b1;
                        d.ad_oe = 1'b0;
                    end
                end
            end
            ebcs_pkg::SEQ_TAIL: begin
                d.cnt = q.cnt + W'(1);
                if (q.cnt == q.len - W'(1)) begin
                    d.st    = ebcs_pkg::SEQ_IDLE;
                    d.done  = 1'b1;
                    d.ad_oe = 1'b0;
                end
            end
            default: begin
                d.st = ebcs_pkg::SEQ_IDLE;
            end
        endcase
        d.idle = (d.st == ebcs_pkg::SEQ_IDLE);
    end

    // reset forces the strobe high and stretch to one
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            q <= RST;
        end else begin
            q <= d;
        end
    end

    assign sfr_rdata_o        = q.sfr_rdata;
    assign idle_o             = q.idle;
    assign done_o             = q.done;
    assign rdata_o            = q.rdata;
    assign ale_o              = q.ale;
    assign mux_addr_data_o    = q.ad;
    assign mux_addr_data_oe_o = q.ad_oe;
    assign addr_hi_o          = q.addr_hi;
    assign rd_n_o             = q.rd_n;
    assign wr_n_o             = q.wr_n;
    assign psen_n_o           = q.psen_n;
    assign timer_tick_o       = q.tick;

    // helper counters watched only by the checks below
    logic [W-1:0] h_cnt;
    logic [W-1:0] h_low;
    logic         h_fetch;
    logic [2:0]   h_s;

    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            h_cnt   <= '0;
            h_low   <= '0;
            h_fetch <= 1'b0;
            h_s     <= 3'd0;
        end else begin
            h_cnt <= start ? '0 : h_cnt + W'(1);
            h_low <= (!rd_n_o || !wr_n_o) ? h_low + W'(1) : '0;
            if (start) begin
                h_fetch <= req_data_i.fetch;
                h_s     <= s_now;
            end
        end
    end

    default clocking @(posedge mclk_i); endclocking
    default disable iff (rst_i);

    a_ale_high_width: assert property (
        $rose(ale_o) |-> ale_o [*3] ##1 !ale_o)
        else $error("address strobe high time wrong");
    a_ale_in_reset: assert property (disable iff (1'b0)
        rst_i |-> ale_o)
        else $error("address strobe low during reset");
    a_addr_before_data: assert property (
        $fell(ale_o) && !idle_o && h_cnt == W'(ebcs_pkg::ALE_HIGH_MCLK)
            |-> $stable(mux_addr_data_o) && mux_addr_data_oe_o)
        else $error("low address not held at strobe fall");
    a_cycle_period: assert property (
        $rose(ale_o) |-> ##8 $rose(ale_o))
        else $error("machine cycle not eight mclk");
    a_ale_once_cycle: assert property (
        $rose(ale_o) |=> (!$rose(ale_o)) [*7])
        else $error("more than one strobe pulse in a cycle");
    a_tick_slow: assert property (
        timer_tick_o && !q.clk_ctrl_reg[ebcs_pkg::TSEL_BIT]
            |=> (!timer_tick_o) [*8])
        else $error("slow timer tick too early");
    a_tick_fast: assert property (
        timer_tick_o && q.clk_ctrl_reg[ebcs_pkg::TSEL_BIT]
            |-> ##8 (timer_tick_o || !q.clk_ctrl_reg[ebcs_pkg::TSEL_BIT]))
        else $error("fast timer tick not every four crystal clocks");
    a_move_length: assert property (
        done_o && !h_fetch |-> h_cnt == ({{(W-3){1'b0}}, h_s}
            + W'(ebcs_pkg::BASE_MC)) * W'(ebcs_pkg::MC_MCLK))
        else $error("data move length does not follow stretch");
    a_stretch_write: assert property (
        sfr_wr_i && sfr_addr_i == ebcs_pkg::CLK_CTRL_ADDR
            |=> s_now == 3'($past(sfr_wdata_i)))
        else $error("stretch field not written");
    a_fetch_unstretched: assert property (
        done_o && h_fetch
            |-> h_cnt == W'(ebcs_pkg::FETCH_MC * ebcs_pkg::MC_MCLK))
        else $error("fetch length changed");
    a_strobe_width: assert property (
        $rose(rd_n_o) || $rose(wr_n_o) |-> h_low == strobe_mclk(h_s))
        else $error("read or write strobe width wrong");

    c_move_fast: cover property (done_o && !h_fetch && h_s == 3'd0);
    c_move_slow: cover property (done_o && !h_fetch && h_s == 3'd7);
    c_fetch: cover property (done_o && h_fetch);
    c_tick_fast: cover property (timer_tick_o
        && q.clk_ctrl_reg[ebcs_pkg::TSEL_BIT]);
endmodule

//--- shared/ebcs_pkg.sv
// constants and carriers shared by the external bus cycle stretch block
package ebcs_pkg;
    // special function space addresses and reset values
    localparam logic [7:0] CLK_CTRL_ADDR = 8'h8E;
    localparam logic [7:0] PORT1_ADDR    = 8'hA0;
    localparam logic [7:0] CLK_CTRL_RST  = 8'h01;
    localparam logic [7:0] PORT1_RST     = 8'hFF;
    // clock control fields
    localparam int STRETCH_LSB = 0;
    localparam int STRETCH_W   = 3;
    localparam int TSEL_BIT    = 3;
    // timing: mclk runs at twice the crystal rate
    localparam int  MCLK_PER_XTAL  = 2;
    localparam int  XTAL_PER_MC    = 4;
    localparam int  MC_MCLK        = XTAL_PER_MC * MCLK_PER_XTAL;
    localparam real ALE_HIGH_XTAL  = 1.5;
    localparam int  ALE_HIGH_MCLK  = int'(ALE_HIGH_XTAL * MCLK_PER_XTAL);
    localparam int  ADDR_HOLD_MCLK = ALE_HIGH_MCLK + 1;
    localparam int  BASE_MC        = 2;
    localparam int  FETCH_MC       = 1;
    localparam int  STRB0_XTAL     = 2;
    localparam int  STRB_STEP_XTAL = 4;
    localparam int  TMR_SLOW_XTAL  = 12;
    localparam int  TMR_FAST_XTAL  = 4;
    localparam int  SEQ_W          = 7;

    typedef struct packed {
        logic        fetch;
        logic        we;
        logic [15:0] addr;
        logic [7:0]  wdata;
    } ebcs_req_type;

    typedef struct packed {
        logic timer2_ext_io;
        logic timer2_capture_trigger;
        logic serial1_receive;
        logic ext_irq_two;
        logic ext_irq_three;
        logic ext_irq_four;
        logic ext_irq_five;
    } ebcs_alt_type;

    typedef enum logic [1:0] {
        SEQ_IDLE, SEQ_ADDR, SEQ_STRB, SEQ_TAIL
    } ebcs_seq_type;

    typedef struct packed {
        ebcs_seq_type     st;
        logic [2:0]       ph;
        logic             ale;
        logic [7:0]       clk_ctrl_reg;
        logic [SEQ_W-1:0] cnt;
        logic [SEQ_W-1:0] len;
        logic [SEQ_W-1:0] sb_start;
        logic [SEQ_W-1:0] sb_end;
        logic             fetch;
        logic             we;
        logic [7:0]       ad;
        logic             ad_oe;
        logic [7:0]       addr_hi;
        logic             rd_n;
        logic             wr_n;
        logic             psen_n;
        logic             done;
        logic             idle;
        logic [7:0]       rdata;
        logic [7:0]       sfr_rdata;
        logic [3:0]       tcnt;
        logic             tick;
    } ebcs_top_state_type;

    typedef struct packed {
        logic [7:0]   latch;
        logic [7:0]   boost;
        logic [7:0]   pin;
        logic [7:0]   oe;
        logic [7:0]   pu;
        logic [7:0]   prev;
        ebcs_alt_type alt;
    } ebcs_port_state_type;
endpackage

//--- tb/ebcs_mem.sv
// external memory behind a transparent low-address latch
`timescale 1ns/1ps
module ebcs_mem (
    // bus from the device
    input  wire logic       ale_i,
    input  wire logic       oe_i,
    input  wire logic [7:0] ad_i,
    input  wire logic       rd_n_i,
    input  wire logic       psen_n_i,
    // data returned on the shared port
    output logic      [7:0] ad_o
);
    logic [7:0] lat_q;
    always_latch begin
        // latch follows the port only while the device drives it
        if (ale_i && oe_i) begin
            lat_q <= ad_i;
        end
    end
    // released port shows the inverse so a stale value never matches
    assign ad_o = (!rd_n_i || !psen_n_i) ? lat_q ^ 8'h5A : ~(lat_q ^ 8'h5A);
endmodule

//--- tb/ebcs_top_test.sv
// self-checking bench for bus timing, stretch and second port
`timescale 1ns/1ps
module ebcs_top_test;
    logic mclk_i = 0, rst_i = 0, sfr_wr = 0, req = 0, tx = 1;
    logic [7:0] sfr_addr = 8'h00, sfr_wdata = 8'h00, mem_o, ad_w;
    logic [7:0] sfr_rdata, ad_o, pin_o, pin_oe, pin_pu, pins;
    ebcs_pkg::ebcs_req_type req_data = '0;
    ebcs_pkg::ebcs_alt_type alt;
    logic idle, done, ale, ad_oe, rd_n, wr_n, psen_n, tick;
    logic [7:0] rdata, addr_hi;
    int n_fail = 0, n_tests = 0;
    assign ad_w = ad_oe ? ad_o : mem_o;
    assign pins = (pin_oe & pin_o) | (~pin_oe & 8'hFF);
    ebcs_top DUT (.mclk_i(mclk_i), .rst_i(rst_i), .sfr_addr_i(sfr_addr),
        .sfr_wr_i(sfr_wr), .sfr_wdata_i(sfr_wdata), .sfr_rdata_o(sfr_rdata),
        .req_i(req), .req_data_i(req_data), .idle_o(idle), .done_o(done),
        .rdata_o(rdata), .ale_o(ale), .mux_addr_data_o(ad_o),
        .mux_addr_data_oe_o(ad_oe), .mux_addr_data_i(ad_w),
        .addr_hi_o(addr_hi), .rd_n_o(rd_n), .wr_n_o(wr_n),
        .psen_n_o(psen_n), .timer_tick_o(tick), .second_port_pins_i(pins),
        .second_port_pins_o(pin_o), .second_port_pins_oe_o(pin_oe),
        .second_port_pins_pu_o(pin_pu), .serial1_transmit_i(tx),
        .alt_o(alt));
    ebcs_mem mem (.ale_i(ale), .oe_i(ad_oe), .ad_i(ad_w), .rd_n_i(rd_n),
        .psen_n_i(psen_n), .ad_o(mem_o));
    initial begin
        forever #2.5 mclk_i = ~mclk_i;
    end
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_fail++;
            $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic step(input int k);
        repeat (k) @(posedge mclk_i);
        #1;
    endtask
    task automatic sfr_write(input logic [7:0] a, input logic [7:0] d);
        sfr_addr <= a;
        sfr_wdata <= d;
        sfr_wr <= 1'b1;
        step(1);
        sfr_wr <= 1'b0;
        step(2);
    endtask
    task automatic results;
        $display("tests %0d mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    task automatic ale_test;
        int h, p;
        h = 0;
        p = 0;
        while (ale !== 1'b0) step(1);
        while (ale !== 1'b1) step(1);
        while (ale === 1'b1 && h < 20) begin
            h++;
            step(1);
        end
        p = h;
        while (ale !== 1'b1 && p < 20) begin
            p++;
            step(1);
        end
        chk(16'(h), 16'd3);
        chk(16'(p), 16'd8);
        $display("ale test done");
    endtask
    task automatic access(input logic f, input logic w, input logic [2:0] s);
        int n, low;
        logic [7:0] lo, wd;
        lo = {5'h15, s};
        wd = 8'h00;
        sfr_write(ebcs_pkg::CLK_CTRL_ADDR, {5'h00, s});
        chk(16'(sfr_rdata), 16'(s));
        req_data <= '{fetch: f, we: w, addr: {8'hC3, lo}, wdata: ~lo};
        req <= 1'b1;
        for (n = 0; n < 40 && idle !== 1'b0; n++) step(1);
        n = 0;
        low = 0;
        while (done !== 1'b1 && n < 200) begin
            step(1);
            n++;
            low += (rd_n === 1'b0 || psen_n === 1'b0 || wr_n === 1'b0);
            if (wr_n === 1'b0) wd = ad_w;
        end
        req <= 1'b0;
        chk(16'(n), f ? 16'd8 : 16'((s + 2) * 8));
        chk(16'(low), (f || s == 0) ? 16'd4 : 16'(s * 8));
        chk({addr_hi, w ? wd : rdata}, {8'hC3, w ? ~lo : lo ^ 8'h5A});
        step(1);
    endtask
    task automatic port_test;
        int hi;
        sfr_write(ebcs_pkg::PORT1_ADDR, 8'hFA);
        step(6);
        chk({pin_oe, pin_o}, 16'h05FA);
        chk(16'(pin_pu), 16'h00FA);
        chk(16'({alt.timer2_ext_io, alt.timer2_capture_trigger,
            alt.serial1_receive}), 16'h0002);
        sfr_addr <= ebcs_pkg::PORT1_ADDR;
        sfr_wdata <= 8'hFF;
        sfr_wr <= 1'b1;
        hi = 0;
        repeat (5) begin
            step(1);
            sfr_wr <= 1'b0;
            hi += (pin_oe[0] === 1'b1 && pin_o[0] === 1'b1);
        end
        chk(16'(hi), 16'd1);
        chk({pin_oe, pin_pu}, {8'h00, 8'hFF});
        tx <= 1'b0;
        step(2);
        chk(16'({pin_oe[3], pin_o[3]}), 16'h0002);
        tx <= 1'b1;
        step(2);
        irq_test(8'h0F, 16'h0101);
        irq_test(8'hFF, 16'h1010);
        $display("port test done");
    endtask
    task automatic irq_test(input logic [7:0] v, input logic [15:0] e);
        logic [15:0] c;
        c = 16'h0000;
        sfr_write(ebcs_pkg::PORT1_ADDR, v);
        repeat (10) begin
            c = c + {3'd0, alt.ext_irq_two, 3'd0, alt.ext_irq_three,
                     3'd0, alt.ext_irq_four, 3'd0, alt.ext_irq_five};
            step(1);
        end
        chk(c, e);
    endtask
    task automatic tick_test;
        int n;
        while (tick !== 1'b1) step(1);
        n = 0;
        do begin
            step(1);
            n++;
        end while (tick !== 1'b1 && n < 100);
        chk(16'(n), 16'd24);
        step(10);
        sfr_write(ebcs_pkg::CLK_CTRL_ADDR, 8'h09);
        while (tick !== 1'b1) step(1);
        n = 0;
        do begin
            step(1);
            n++;
        end while (tick !== 1'b1 && n < 100);
        chk(16'(n), 16'd8);
        $display("timer test done");
    endtask
    initial begin
        repeat (20000) @(posedge mclk_i);
        n_fail++;
        results();
    end
    initial begin
        rst_i <= 1'b1;
        step(6);
        chk(16'(ale), 16'd1);
        rst_i <= 1'b0;
        sfr_addr <= ebcs_pkg::CLK_CTRL_ADDR;
        step(2);
        chk(16'(sfr_rdata), 16'h0001);
        chk({pin_oe, pin_pu}, {8'h00, 8'hFF});
        ale_test();
        tick_test();
        for (int s = 0; s < 8; s++) access(1'b0, 1'b0, 3'(s));
        access(1'b1, 1'b0, 3'd7);
        access(1'b0, 1'b1, 3'd3);
        $display("access test done");
        port_test();
        results();
    end
endmodule
